// ### design/mnu_map.svh
`ifndef MNU_MAP_SVH
`define MNU_MAP_SVH
// Clock rate in kHz, so that milliseconds times this give cycles.
`define MNU_CLK_KHZ 64'd125000
// Times in milliseconds.
`define MNU_DEB_MS 64'd10
`define MNU_LONG_MS 64'd2000
`define MNU_QV_MS 64'd5000
`define MNU_MENU_MS 64'd60000
`define MNU_SHOW_MS 64'd3000
`define MNU_ERR_MS 64'd2000
`define MNU_ALT_MS 64'd1000
`define MNU_SLOW_MS 64'd250
`define MNU_FAST_MS 64'd10
// Register byte offsets.
`define MNU_REG_CTRL 8'h00
`define MNU_REG_PWD 8'h04
`define MNU_REG_STAT 8'h08
// Control fields and reset values.
`define MNU_CTRL_SLIDE 0
`define MNU_CTRL_FREE 1
`define MNU_CTRL_RST 2'h0
`define MNU_PWD_RST 16'h0000
// Position code of the sign in digit editing.
`define MNU_SIGN_POS 3'h6
// Label code shown for the batch count in quick view.
`define MNU_BATCH_LABEL 8'hFF
`endif

// ### design/mnu_pkg.sv
package mnu_pkg;

  // Operating states, one-hot.
  typedef enum logic [9:0] {
    ST_MEAS = 10'h001,
    ST_QVIEW = 10'h002,
    ST_PWD = 10'h004,
    ST_ERR = 10'h008,
    ST_BROWSE = 10'h010,
    ST_EDD = 10'h020,
    ST_EDS = 10'h040,
    ST_EDL = 10'h080,
    ST_CONF = 10'h100,
    ST_SHOW = 10'h200
  } mnu_state_type;

  // What the display shows.
  typedef enum logic [2:0] {
    DK_MEAS = 3'h0,
    DK_LABEL = 3'h1,
    DK_VALUE = 3'h2,
    DK_PASSWORD = 3'h3,
    DK_ERROR = 3'h4,
    DK_PROMPT = 3'h5
  } mnu_disp_kind_type;

  // Signed value held as six BCD digits.
  typedef struct packed {
    logic neg;
    logic [23:0] bcd;
  } mnu_value_type;

  typedef struct packed {
    mnu_disp_kind_type kind;
    logic [7:0] item;
    mnu_value_type val;
    logic [2:0] flash;
  } mnu_disp_type;

  typedef struct packed {
    logic [7:0] addr;
    mnu_value_type data;
  } mnu_nv_type;

endpackage : mnu_pkg

// ### design/mnu_button.sv
`timescale 1ns/1ps
module mnu_button #(
  parameter longint unsigned DEB_CYC = 64'd1250000,
  parameter longint unsigned LONG_CYC = 64'd250000000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Raw button pin, high while pressed.
  input wire logic pin,
  // Debounced events.
  output logic held,
  output logic press,
  output logic short_rel,
  output logic long_hit
);

  logic sync1;
  logic sync2;
  logic held_q;
  logic long_seen;
  logic [31:0] dcnt;
  logic [31:0] hcnt;

  // Two flip-flops bring the pin into the clock domain.
  always_ff @(posedge clk_sys) begin
    sync1 <= pin;
    sync2 <= sync1;
  end

  // The level must stay changed for the whole debounce time before it is taken.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      held <= 1'b0;
      dcnt <= 32'h0;
    end else if (sync2 == held) begin
      dcnt <= 32'h0;
    end else if (dcnt == 32'(DEB_CYC - 64'd1)) begin
      held <= sync2; // [R21]
      dcnt <= 32'h0;
    end else begin
      dcnt <= dcnt + 32'h1;
    end
  end

  // Hold time decides between a short release and a long press.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      held_q <= 1'b0;
      press <= 1'b0;
      short_rel <= 1'b0;
      long_hit <= 1'b0;
      long_seen <= 1'b0;
      hcnt <= 32'h0;
    end else begin
      held_q <= held;
      press <= held & ~held_q;
      short_rel <= ~held & held_q & ~long_seen; // [R21]
      long_hit <= held & (hcnt == 32'(LONG_CYC - 64'd1)); // [R21]
      hcnt <= held ? hcnt + 32'h1 : 32'h0;
      if (held & (hcnt == 32'(LONG_CYC - 64'd1))) begin
        long_seen <= 1'b1;
      end else if (~held) begin
        long_seen <= 1'b0;
      end
    end
  end

endmodule : mnu_button

// ### design/mnu_slide.sv
`timescale 1ns/1ps
module mnu_slide #(
  parameter longint unsigned SLOW_CYC = 64'd31250000,
  parameter longint unsigned FAST_CYC = 64'd1250000
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Slide editing active and button levels.
  input wire logic en,
  input wire logic up,
  input wire logic down,
  // Step pulses.
  output logic inc,
  output logic dec
);

  logic [31:0] ivl;
  logic [31:0] cnt;
  logic dir_up;
  logic both;
  logic dir;

  assign both = up & down;
  assign dir = both ? dir_up : up;

  // Each step shortens the interval by an eighth, so the rate rises while held until the interval reaches FAST_CYC.
  // Both buttons together pin the interval at the slow end.
  always_ff @(posedge clk_sys) begin
    if (srst | ~en | ~(up | down)) begin
      ivl <= 32'(SLOW_CYC);
      cnt <= 32'(SLOW_CYC);
      inc <= 1'b0;
      dec <= 1'b0;
      dir_up <= 1'b1;
    end else begin
      if (!both) begin
        dir_up <= up;
      end
      if (cnt >= ivl) begin
        cnt <= 32'h0;
        inc <= dir; // [R17]
        dec <= ~dir; // [R18]
        if (both) begin
          ivl <= 32'(SLOW_CYC); // [R17] [R18]
        end else if (ivl - (ivl >> 3) > 32'(FAST_CYC)) begin
          ivl <= ivl - (ivl >> 3); // [R17] [R18]
        end else begin
          ivl <= 32'(FAST_CYC);
        end
      end else begin
        cnt <= cnt + 32'h1;
        inc <= 1'b0;
        dec <= 1'b0;
        if (both) begin
          ivl <= 32'(SLOW_CYC);
        end
      end
    end
  end

endmodule : mnu_slide

// ### design/mnu_front_panel.sv
// Behaviour
// (R1) Menu opens from measurement only after escape held two seconds.
// (R2) Password entry shows only the edited digit, dashes elsewhere.
// (R3) After last password digit: first menu item if correct, else error.
// (R4) Up or down on flow or batch display opens quick view, label alternating.
// (R5) Quick view: press within five seconds advances, else back to measurement.
// (R6) With free access, enter in quick view edits the shown threshold.
// (R7) After a quick-view confirm, new value alternates with label some seconds.
// (R8) In menus up and down step items and show the selected name.
// (R9) Enter on a submenu name descends and shows its first item.
// (R10) Enter on a parameter name starts editing and shows its value.
// (R11) Escape goes one level up, or to measurement from the top.
// (R12) One minute without buttons leaves menu, except while editing.
// (R13) A setting selects digit editing or slide editing.
// (R14) Digit edit: up/down change flashing digit or sign, short enter moves.
// (R15) Enter held two seconds ends numeric editing with confirmation prompt.
// (R16) At prompt short enter stores to memory, short escape discards.
// (R17) Slide: holding up accelerates increase; down slows, both keep slow.
// (R18) Slide: holding down accelerates decrease; up slows, both keep slow.
// (R19) List: up/down choose, enter prompts, second enter stores, escape cancels.
// (R20) A nonzero password is asked every entry; wrong entry returns to measurement.
// (R21) Buttons are debounced and press durations timed from the clock.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "mnu_map.svh"
module mnu_front_panel
  import mnu_pkg::*;
#(
  parameter int unsigned NSUB = 8,
  parameter int unsigned NPAR = 4,
  parameter int unsigned NTHR = 2,
  parameter int unsigned NLIST = 4,
  parameter longint unsigned DEB_CYC = `MNU_DEB_MS * `MNU_CLK_KHZ,
  parameter longint unsigned LONG_CYC = `MNU_LONG_MS * `MNU_CLK_KHZ,
  parameter longint unsigned QV_CYC = `MNU_QV_MS * `MNU_CLK_KHZ,
  parameter longint unsigned MENU_CYC = `MNU_MENU_MS * `MNU_CLK_KHZ,
  parameter longint unsigned SHOW_CYC = `MNU_SHOW_MS * `MNU_CLK_KHZ,
  parameter longint unsigned ERR_CYC = `MNU_ERR_MS * `MNU_CLK_KHZ,
  parameter longint unsigned ALT_CYC = `MNU_ALT_MS * `MNU_CLK_KHZ,
  parameter longint unsigned SLOW_CYC = `MNU_SLOW_MS * `MNU_CLK_KHZ,
  parameter longint unsigned FAST_CYC = `MNU_FAST_MS * `MNU_CLK_KHZ
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Button pins, high while pressed.
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic enter_pin,
  input wire logic escape_menu_button_pin,
  // Measurement side status, same clock.
  input wire logic qv_allowed,
  input wire mnu_value_type batch_count,
  // Display and non-volatile store.
  output mnu_disp_type disp,
  output logic meas_mode,
  output logic nv_wr,
  output mnu_nv_type nv,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int unsigned SW = $clog2(NSUB);
  localparam int unsigned PW = $clog2(NPAR);
  localparam int unsigned IW = $clog2(NSUB * NPAR);

  mnu_state_type state;
  logic [35:0] tmr;
  logic [35:0] alt_cnt;
  logic alt;
  mnu_value_type edit;
  logic [2:0] pos;
  logic lvl;
  logic [SW-1:0] sub;
  logic [PW-1:0] par;
  logic [IW-1:0] qi;
  logic [IW-1:0] eidx;
  logic from_qv;
  logic [1:0] ctrl;
  logic [15:0] pwd_reg;
  mnu_value_type val [NSUB*NPAR];
  logic up_h, dn_h, en_h, esc_h;
  logic up_p, dn_p, en_p, esc_p;
  logic up_s, dn_s, en_s, esc_s;
  logic up_l, dn_l, en_l, esc_l;
  logic sl_inc, sl_dec;
  logic any_p;
  logic wr_go;
  logic [IW-1:0] cur_idx;

  ////////////////////////////////////////////////////////////////////////////
  // Buttons and slide stepping.

  mnu_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_up (.clk_sys(clk_sys), .srst(srst),
    .pin(up_pin), .held(up_h), .press(up_p), .short_rel(up_s), .long_hit(up_l));
  mnu_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_dn (.clk_sys(clk_sys), .srst(srst),
    .pin(down_pin), .held(dn_h), .press(dn_p), .short_rel(dn_s), .long_hit(dn_l));
  mnu_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_en (.clk_sys(clk_sys), .srst(srst),
    .pin(enter_pin), .held(en_h), .press(en_p), .short_rel(en_s), .long_hit(en_l));
  mnu_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_esc (.clk_sys(clk_sys), .srst(srst),
    .pin(escape_menu_button_pin), .held(esc_h), .press(esc_p), .short_rel(esc_s),
    .long_hit(esc_l));

  mnu_slide #(.SLOW_CYC(SLOW_CYC), .FAST_CYC(FAST_CYC)) u_slide (.clk_sys(clk_sys),
    .srst(srst), .en(state == ST_EDS), .up(up_h), .down(dn_h), .inc(sl_inc), .dec(sl_dec));

  // Every press restarts the menu inactivity time.
  assign any_p = up_p | dn_p | en_p | esc_p;
  assign wr_go = (state == ST_CONF) & en_s;
  assign cur_idx = IW'(32'(sub) * NPAR + 32'(par));

  ////////////////////////////////////////////////////////////////////////////
  // Value arithmetic.

  // One BCD step of the magnitude, up or down by one.
  function automatic logic [23:0] bcd_step(input logic [23:0] m, input logic up);
    logic [23:0] r;
    logic c;
    r = m;
    c = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (c) begin
        if (up) begin
          c = (r[4*i+:4] == 4'h9);
          r[4*i+:4] = c ? 4'h0 : r[4*i+:4] + 4'h1;
        end else begin
          c = (r[4*i+:4] == 4'h0);
          r[4*i+:4] = c ? 4'h9 : r[4*i+:4] - 4'h1;
        end
      end
    end
    return r;
  endfunction : bcd_step

  // Signed step; the magnitude saturates and zero is always positive.
  function automatic mnu_value_type val_step(input mnu_value_type v, input logic up);
    mnu_value_type r;
    r = v;
    if (up ^ v.neg) begin
      if (v.bcd != 24'h999999) r.bcd = bcd_step(v.bcd, 1'b1);
    end else if (v.bcd == 24'h000000) begin
      r.neg = 1'b1;
      r.bcd = 24'h000001;
    end else begin
      r.bcd = bcd_step(v.bcd, 1'b0);
      if (r.bcd == 24'h000000) r.neg = 1'b0;
    end
    return r;
  endfunction : val_step

  // Change one digit, wrapping within 0 to 9, or flip the sign.
  function automatic mnu_value_type dig_step(input mnu_value_type v, input logic [2:0] p,
                                             input logic up);
    mnu_value_type r;
    logic [3:0] n;
    r = v;
    n = v.bcd[4*p+:4];
    if (p == `MNU_SIGN_POS) r.neg = ~v.neg;
    else if (up) r.bcd[4*p+:4] = (n == 4'h9) ? 4'h0 : n + 4'h1;
    else r.bcd[4*p+:4] = (n == 4'h0) ? 4'h9 : n - 4'h1;
    return r;
  endfunction : dig_step

  ////////////////////////////////////////////////////////////////////////////
  // Operating state, timeout and edit buffer.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_MEAS;
      tmr <= 36'h0;
      edit <= '0;
      pos <= 3'h0;
      lvl <= 1'b0;
      sub <= '0;
      par <= '0;
      qi <= '0;
      eidx <= '0;
      from_qv <= 1'b0;
    end else begin
      if (tmr != 36'h0) tmr <= tmr - 36'h1;
      case (state)
        ST_MEAS: begin
          if (esc_l) begin // [R1]
            tmr <= 36'(MENU_CYC);
            lvl <= 1'b0;
            sub <= '0;
            edit <= '0;
            pos <= 3'h3;
            state <= (pwd_reg != 16'h0000) ? ST_PWD : ST_BROWSE; // [R20]
          end else if (qv_allowed & (up_p | dn_p)) begin
            qi <= '0; // [R4]
            tmr <= 36'(QV_CYC);
            state <= ST_QVIEW;
          end
        end
        ST_QVIEW, ST_SHOW: begin
          if (up_p | dn_p) begin
            tmr <= 36'(QV_CYC); // [R5]
            state <= ST_QVIEW;
            if (up_p) qi <= (qi == IW'(NTHR)) ? '0 : qi + IW'(1);
            else qi <= (qi == '0) ? IW'(NTHR) : qi - IW'(1);
          end else if (en_s & ctrl[`MNU_CTRL_FREE] & (qi < IW'(NTHR))) begin
            edit <= val[qi]; // [R6]
            eidx <= qi;
            from_qv <= 1'b1;
            pos <= 3'h5;
            state <= ctrl[`MNU_CTRL_SLIDE] ? ST_EDS : ST_EDD; // [R13]
          end else if (esc_s | (tmr == 36'h0)) begin
            state <= ST_MEAS; // [R5] [R7]
          end
        end
        ST_PWD: begin
          if (any_p) tmr <= 36'(MENU_CYC);
          if (up_p | dn_p) begin
            edit <= dig_step(edit, pos, up_p); // [R2]
          end else if (en_s & (pos != 3'h0)) begin
            pos <= pos - 3'h1;
          end else if (en_s) begin
            tmr <= 36'(ERR_CYC);
            state <= (edit.bcd[15:0] == pwd_reg) ? ST_BROWSE : ST_ERR; // [R3]
            if (edit.bcd[15:0] == pwd_reg) tmr <= 36'(MENU_CYC);
          end else if (esc_s | (tmr == 36'h0)) begin
            state <= ST_MEAS;
          end
        end
        ST_ERR: begin
          if (tmr == 36'h0) state <= ST_MEAS; // [R20]
        end
        ST_BROWSE: begin
          if (any_p) tmr <= 36'(MENU_CYC); // [R12]
          if (up_p & ~lvl) sub <= (sub == SW'(NSUB - 1)) ? '0 : sub + SW'(1); // [R8]
          else if (dn_p & ~lvl) sub <= (sub == '0) ? SW'(NSUB - 1) : sub - SW'(1);
          else if (up_p) par <= (par == PW'(NPAR - 1)) ? '0 : par + PW'(1); // [R8]
          else if (dn_p) par <= (par == '0) ? PW'(NPAR - 1) : par - PW'(1);
          else if (en_s & ~lvl) begin
            lvl <= 1'b1; // [R9]
            par <= '0;
          end else if (en_s) begin
            edit <= val[cur_idx]; // [R10]
            eidx <= cur_idx;
            from_qv <= 1'b0;
            pos <= 3'h5;
            if (par == PW'(NPAR - 1)) state <= ST_EDL;
            else state <= ctrl[`MNU_CTRL_SLIDE] ? ST_EDS : ST_EDD; // [R13]
          end else if (esc_s & lvl) begin
            lvl <= 1'b0; // [R11]
          end else if (esc_s | (tmr == 36'h0)) begin
            state <= ST_MEAS; // [R11] [R12]
          end
        end
        ST_EDD, ST_EDS, ST_EDL: begin
          if (state == ST_EDD & (up_p | dn_p)) begin
            edit <= dig_step(edit, pos, up_p); // [R14]
          end else if (state == ST_EDD & en_s) begin
            pos <= (pos == `MNU_SIGN_POS) ? 3'h5 : (pos == 3'h0) ? `MNU_SIGN_POS : pos - 3'h1;
          end else if (state == ST_EDS & (sl_inc | sl_dec)) begin
            edit <= val_step(edit, sl_inc); // [R17] [R18]
          end else if (state == ST_EDL & (up_p | dn_p)) begin
            edit.neg <= 1'b0; // [R19]
            if (up_p) edit.bcd <= (edit.bcd >= 24'(NLIST - 1)) ? 24'h0 : edit.bcd + 24'h1;
            else edit.bcd <= (edit.bcd == 24'h0) ? 24'(NLIST - 1) : edit.bcd - 24'h1;
          end else if ((state == ST_EDL) ? en_s : en_l) begin
            state <= ST_CONF; // [R15] [R19]
          end else if (esc_s) begin
            tmr <= from_qv ? 36'(QV_CYC) : 36'(MENU_CYC);
            state <= from_qv ? ST_QVIEW : ST_BROWSE;
          end
        end
        ST_CONF: begin
          if (en_s | esc_s) begin
            tmr <= from_qv ? 36'(en_s ? SHOW_CYC : QV_CYC) : 36'(MENU_CYC); // [R16]
            state <= from_qv ? (en_s ? ST_SHOW : ST_QVIEW) : ST_BROWSE; // [R7] [R16]
          end
        end
        default: begin
          state <= ST_MEAS;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored parameter values and the write toward non-volatile memory.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NSUB * NPAR; i++) val[i] <= '0;
      nv_wr <= 1'b0;
      nv <= '0;
    end else begin
      nv_wr <= wr_go;
      if (wr_go) begin
        val[eidx] <= edit; // [R16] [R19]
        nv.addr <= 8'(eidx);
        nv.data <= edit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display.

  // Label and value alternate on a fixed period.
  always_ff @(posedge clk_sys) begin
    if (srst | (alt_cnt == 36'(ALT_CYC - 64'd1))) begin
      alt_cnt <= 36'h0;
      alt <= srst ? 1'b0 : ~alt;
    end else begin
      alt_cnt <= alt_cnt + 36'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      disp <= '0;
      meas_mode <= 1'b1;
    end else begin
      meas_mode <= (state == ST_MEAS);
      disp.flash <= (state == ST_EDD || state == ST_PWD) ? pos : 3'h0;
      disp.item <= 8'(lvl ? cur_idx : IW'(sub));
      disp.val <= edit;
      case (state)
        ST_QVIEW, ST_SHOW: begin
          disp.kind <= alt ? DK_LABEL : DK_VALUE; // [R4] [R7]
          disp.item <= (qi == IW'(NTHR)) ? `MNU_BATCH_LABEL : 8'(qi);
          disp.val <= (qi == IW'(NTHR)) ? batch_count : val[qi];
        end
        ST_PWD: begin
          disp.kind <= DK_PASSWORD;
          disp.val.neg <= 1'b0;
          for (int i = 0; i < 6; i++) begin
            disp.val.bcd[4*i+:4] <= (3'(i) == pos) ? edit.bcd[4*i+:4] : 4'hF; // [R2]
          end
        end
        ST_BROWSE: disp.kind <= DK_LABEL; // [R8]
        ST_EDD, ST_EDS, ST_EDL: disp.kind <= DK_VALUE; // [R10]
        ST_CONF: disp.kind <= DK_PROMPT; // [R15]
        ST_ERR: disp.kind <= DK_ERROR; // [R3]
        default: disp.kind <= DK_MEAS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers: one wait state, error on unmapped offsets.

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl <= `MNU_CTRL_RST;
      pwd_reg <= `MNU_PWD_RST;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (psel & penable & ~pready) begin
        case (paddr)
          `MNU_REG_CTRL: prdata <= {30'h0, ctrl};
          `MNU_REG_PWD: prdata <= {16'h0, pwd_reg};
          `MNU_REG_STAT: prdata <= {8'h0, 8'(qi), 1'b0, 3'(sub), 1'(lvl), 1'b0, 10'(state)};
          default: begin
            prdata <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (psel & penable & pready & pwrite) begin
        if (paddr == `MNU_REG_CTRL) ctrl <= pwdata[1:0]; // [R13]
        if (paddr == `MNU_REG_PWD) pwd_reg <= pwdata[15:0]; // [R20]
      end
    end
  end

endmodule : mnu_front_panel

// ### dv/mnu_fp_asserts.sv
`timescale 1ns/1ps
module mnu_fp_chk
  import mnu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Buttons.
  input wire logic up_pin,
  input wire logic down_pin,
  input wire logic escape_menu_button_pin,
  // Display and store.
  input wire mnu_disp_type disp,
  input wire logic meas_mode,
  input wire logic nv_wr,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////
  // A stray figure beside the edited digit would leak the password.
  logic pwd_ok;
  always_comb begin
    pwd_ok = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i != int'(disp.flash) && disp.val.bcd[4*i+:4] != 4'hF) begin
        pwd_ok = 1'b0;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_unm;
    pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr && prdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not refused");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_menu; $fell(meas_mode) |-> up_pin || down_pin || escape_menu_button_pin; endproperty
  a_menu: assert property (p_menu) else $error("left measurement unasked");
  property p_pwd; disp.kind == DK_PASSWORD |-> pwd_ok; endproperty
  a_pwd: assert property (p_pwd) else $error("password digits shown");
  property p_back; $rose(disp.kind == DK_ERROR) |-> ##[1:60] meas_mode; endproperty
  a_back: assert property (p_back) else $error("no return after error");
  property p_meas; $rose(meas_mode) |=> disp.kind == DK_MEAS; endproperty
  a_meas: assert property (p_meas) else $error("display not in measurement");
  property p_nv; nv_wr |-> $past(disp.kind) == DK_PROMPT ##1 !nv_wr; endproperty
  a_nv: assert property (p_nv) else $error("store without prompt");
  property p_flash;
    disp.kind != DK_PASSWORD && disp.kind != DK_VALUE |-> disp.flash == 3'h0;
  endproperty
  a_flash: assert property (p_flash) else $error("flash outside editing");
  // Main scenarios.
  c_nv: cover property (nv_wr);
  c_err: cover property (disp.kind == DK_ERROR);
  c_unm: cover property (pslverr);
endmodule : mnu_fp_chk

bind mnu_front_panel mnu_fp_chk mnu_fp_chk_inst (
  .clk_sys(clk_sys), .srst(srst), .up_pin(up_pin), .down_pin(down_pin),
  .escape_menu_button_pin(escape_menu_button_pin), .disp(disp),
  .meas_mode(meas_mode), .nv_wr(nv_wr), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ### dv/mnu_operator.sv
`timescale 1ns/1ps
module mnu_operator (
  // Clock.
  input wire logic clk_sys,
  // Buttons the operator means to hold, and the contact levels.
  input wire logic [3:0] want,
  output logic [3:0] pins = 4'h0
);
  logic [3:0] last = 4'h0;
  logic [3:0] chg = 4'h0;
  logic [1:0] cnt = 2'h0;
  // A changed contact chatters for two cycles; the others stay quiet.
  always @(posedge clk_sys) begin
    if (want != last) begin
      last <= want;
      chg <= want ^ last;
      cnt <= 2'h2;
      pins <= want;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
      pins <= (cnt == 2'h1) ? last : last ^ chg;
    end
  end
endmodule : mnu_operator

// ### dv/mnu_front_panel_bench.sv
`timescale 1ns/1ps
module mnu_front_panel_bench
  import mnu_pkg::*;
;
  logic clk_sys, srst, qv_allowed, psel, penable, pwrite, perr;
  logic meas_mode, nv_wr, pready, pslverr;
  logic [3:0] want, pins;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  mnu_disp_type disp;
  mnu_value_type bcnt;
  mnu_nv_type nv, nv_last;
  int err_total = 0, n_compared = 0, nv_seen = 0;
  //////////////////////////////////////////////////////////////////////
  // Counts are shortened so a full minute of menu idling costs 400 cycles.
  localparam longint unsigned DEB = 4, LNG = 40, QVW = 200, MNU = 400, SHW = 100, ERT = 50,
    ALT = 20, SLW = 32, FST = 4;
  mnu_front_panel #(.DEB_CYC(DEB), .LONG_CYC(LNG), .QV_CYC(QVW), .MENU_CYC(MNU),
    .SHOW_CYC(SHW), .ERR_CYC(ERT), .ALT_CYC(ALT), .SLOW_CYC(SLW), .FAST_CYC(FST))
  mnu_front_panel_inst (.clk_sys(clk_sys), .srst(srst), .up_pin(pins[0]),
    .down_pin(pins[1]), .enter_pin(pins[2]), .escape_menu_button_pin(pins[3]),
    .qv_allowed(qv_allowed), .batch_count(bcnt), .disp(disp),
    .meas_mode(meas_mode), .nv_wr(nv_wr), .nv(nv), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  mnu_operator mnu_operator_inst (.clk_sys(clk_sys), .want(want), .pins(pins));
  //////////////////////////////////////////////////////////////////////
  // Clock and store monitor; the store strobe lasts one cycle only.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (nv_wr === 1'b1) begin
      nv_seen <= nv_seen + 1;
      nv_last <= nv;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task st;
    apb(1'b0, 8'h08, 32'h0);
  endtask : st
  // Holds of 14 are short presses, 60 are long.
  task btn(input logic [3:0] m, input int hold);
    @(posedge clk_sys);
    want <= m;
    repeat (hold) @(posedge clk_sys);
    want <= 4'h0;
    repeat (15) @(posedge clk_sys);
  endtask : btn
  //////////////////////////////////////////////////////////////////////
  task s_regs;
    apb(1'b0, 8'h00, 32'h0); chk(q, 32'h0);
    apb(1'b0, 8'h04, 32'h0); chk(q, 32'h0);
    st(); chk(q, 32'h1);
    apb(1'b0, 8'h0C, 32'h0); chk({31'h0, perr}, 32'h1); chk(q, 32'h0);
  endtask : s_regs
  task s_qview;
    qv_allowed <= 1'b1;
    btn(4'h1, 14); st(); chk(32'(q[9:0]), 32'h2);
    chk(32'(disp.item), 32'h0);
    btn(4'h2, 14); chk(32'(disp.item), 32'hFF);
    chk(32'(disp.val), 32'h123);
    repeat (230) @(posedge clk_sys);
    st(); chk(32'(q[9:0]), 32'h1);
  endtask : s_qview
  task s_menu;
    btn(4'h8, 60); st(); chk(32'(q[9:0]), 32'h10);
    btn(4'h1, 14); chk(32'(disp.item), 32'h1);
    btn(4'h4, 14); chk(32'(disp.item), 32'h4);
    btn(4'h4, 14); st(); chk(32'(q[9:0]), 32'h20);
    chk(32'(disp.kind), 32'(DK_VALUE));
    btn(4'h1, 14); chk(32'(disp.val.bcd), 32'h100000);
    btn(4'h4, 14); chk(32'(disp.flash), 32'h4);
    btn(4'h4, 60); chk(32'(disp.kind), 32'(DK_PROMPT));
    btn(4'h4, 14); chk(32'(nv_seen), 32'h1);
    chk(32'(nv_last.data.bcd), 32'h100000);
    st(); chk(32'(q[11:0]), 32'h810);
    btn(4'h8, 14); st(); chk(32'(q[11:0]), 32'h010);
    repeat (450) @(posedge clk_sys);
    st(); chk(32'(q[9:0]), 32'h1);
  endtask : s_menu
  task s_pwd;
    apb(1'b1, 8'h04, 32'h1);
    btn(4'h8, 60); st(); chk(32'(q[9:0]), 32'h4);
    chk(32'(disp.flash), 32'h3);
    repeat (3) btn(4'h4, 14);
    btn(4'h1, 14); btn(4'h4, 14); st(); chk(32'(q[9:0]), 32'h10);
    btn(4'h8, 14); btn(4'h8, 60);
    repeat (4) btn(4'h4, 14);
    st(); chk(32'(q[9:0]), 32'h8);
    repeat (60) @(posedge clk_sys);
    st(); chk(32'(q[9:0]), 32'h1);
    apb(1'b1, 8'h04, 32'h0);
  endtask : s_pwd
  task s_qedit;
    apb(1'b1, 8'h00, 32'h3);
    btn(4'h1, 14); btn(4'h4, 14); st(); chk(32'(q[9:0]), 32'h40);
    btn(4'h2, 20); chk(32'(disp.val), 32'h1000001);
    repeat (2) btn(4'h1, 20); chk(32'(disp.val), 32'h1);
    btn(4'h4, 60); btn(4'h4, 14); st(); chk(32'(q[9:0]), 32'h200);
  endtask : s_qedit
  //////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // The whole run needs about 2000 cycles; a hang is cut off well after.
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  initial begin
    srst = 1'b1; qv_allowed = 1'b0; want = 4'h0; psel = 1'b0; bcnt = 25'h0000123;
    penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    s_regs();
    s_qview();
    s_menu();
    s_pwd();
    s_qedit();
    wrap_up();
  end
endmodule : mnu_front_panel_bench
